// ---- pkg/iesm_pkg.sv ----
// constants, register map, fault layout and types of the encoder monitor
// assumes a 40 MHz system clock and a 32-bit classic wishbone register bus
package iesm_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ         = 40_000_000;  // system clock rate
    localparam int unsigned FMAX_HZ        = 200_000;     // highest checked rate
    localparam int unsigned FMAX_HC_HZ     = 100_000;     // high-current limit
    localparam int unsigned PER_MIN_CYC    = (CLK_HZ + FMAX_HZ - 1) / FMAX_HZ;
    localparam int unsigned PER_MIN_HC_CYC = (CLK_HZ + FMAX_HC_HZ - 1)
                                             / FMAX_HC_HZ;
    localparam int unsigned SETTLE_NS      = 500;         // driver settle time
    localparam int unsigned SETTLE_CYC     = (SETTLE_NS * (CLK_HZ / 1_000_000)
                                             + 999) / 1000;
    localparam int unsigned REG_TICK_NS    = 10_000;      // light loop step
    localparam int unsigned REG_TICK_CYC   = (REG_TICK_NS
                                             * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned RECUR_WIN_MS   = 1000;        // recurrence window
    localparam int unsigned RECUR_WIN_CYC  = RECUR_WIN_MS * (CLK_HZ / 1000);
    localparam int unsigned PER_W          = 12;          // period counter bits

    // register byte addresses
    localparam logic [7:0] ADR_CTRL   = 8'h00;  // output type select
    localparam logic [7:0] ADR_RES    = 8'h04;  // counts per revolution
    localparam logic [7:0] ADR_FAULT  = 8'h08;  // fault flags, write 0 acks
    localparam logic [7:0] ADR_IRQST  = 8'h0c;  // sticky events, read clears
    localparam logic [7:0] ADR_IRQMSK = 8'h10;  // interrupt mask
    localparam logic [7:0] ADR_STATUS = 8'h14;  // encoded status, read only
    localparam logic [7:0] ADR_COUNT  = 8'h18;  // live count since index
    localparam logic [7:0] ADR_QTHR   = 8'h1c;  // scanning quality threshold
    localparam logic [7:0] ADR_SETP   = 8'h20;  // light level setpoint
    localparam logic [7:0] ADR_LED    = 8'h24;  // light current, read only

    // fault bit positions
    localparam int unsigned F_TRANS  = 0;
    localparam int unsigned F_RES    = 1;
    localparam int unsigned F_MISS   = 2;
    localparam int unsigned F_OUTAB  = 3;
    localparam int unsigned F_OUTIDX = 4;
    localparam int unsigned F_RSRV   = 5;
    localparam int unsigned F_LFAIL  = 6;
    localparam int unsigned F_LOWSIG = 7;
    localparam int unsigned F_SYS    = 8;
    localparam int unsigned F_QUAL   = 9;
    localparam int unsigned NFAULT   = 10;

    // reset values
    localparam logic [15:0] RES_RST  = 16'h0400;
    localparam logic [7:0]  QTHR_RST = 8'h0a;   // ten percent quality
    localparam logic [7:0]  SETP_RST = 8'h80;
    localparam logic [9:0]  LED_MAX  = 10'h3ff;
    localparam logic [9:0]  LED_RSRV = 10'h3c0; // reserve nearly used up

    // overall encoder status
    typedef enum logic [2:0] {
        ST_NORMAL   = 3'h0,
        ST_WARNING  = 3'h1,
        ST_SERIOUS  = 3'h2,
        ST_CRITICAL = 3'h3,
        ST_UPDATING = 3'h4
    } iesm_status_type;

endpackage : iesm_pkg

// ---- hw/iesm_sync.sv ----
// two-flop synchroniser for a group of independent pin levels
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/1ps
module iesm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    import iesm_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;  // first stage, read by second stage only
        logic [W-1:0] s2;  // second stage, safe to use
    } iesm_sync_type;

    iesm_sync_type s_r;
    iesm_sync_type s_nxt;

    // shift the pins through both stages
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = d_i;
        s_nxt.s2 = s_r.s1;
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_o = s_r.s2;

endmodule : iesm_sync

// ---- hw/iesm_recur.sv ----
// recurrence grader: turns repeated fault events into a severity level
// assumes event_i is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module iesm_recur #(
    parameter int unsigned WIN_CYC = iesm_pkg::RECUR_WIN_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       event_i,
    output logic      [1:0] level_o
);
    import iesm_pkg::*;

    typedef struct packed {
        logic [1:0]  cnt;  // 0 none, 1 orange, 2 flashing red, 3 steady red
        logic [31:0] win;  // quiet time since the last event or step down
    } iesm_recur_type;

    iesm_recur_type s_r;
    iesm_recur_type s_nxt;

    // each event raises the grade up to steady red; a quiet window lowers it by one step
    always_comb begin
        s_nxt = s_r;
        if (event_i) begin
            if (s_r.cnt != 2'h3) begin
                s_nxt.cnt = s_r.cnt + 2'h1;
            end
            s_nxt.win = '0;
        end else if (s_r.cnt != 2'h0) begin
            if (s_r.win >= WIN_CYC - 1) begin
                s_nxt.cnt = s_r.cnt - 2'h1;
                s_nxt.win = '0;
            end else begin
                s_nxt.win = s_r.win + 32'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level_o = s_r.cnt;

endmodule : iesm_recur

// ---- hw/iesm_monitor.sv ----
// incremental encoder signal monitor: quadrature, index, output and optics
// assumes pins are asynchronous, adc values are on clk_i, wishbone classic
// Functional notes
// - illegal phase state change raises transition alarm
// - index-to-index count must equal resolution or zero
// - count reaching twice resolution means index missing
// - first step after index fixes counting direction
// - reverse to zero without index alarms at once
// - phase outputs checked against internal, within rate
// - index output checked against internal, within rate
// - output faults only warn, never touch counting
// - counting faults graded orange to steady red
// - regulate light current, alarm on low reserve
// - light source failure gives steady red alarm
// - low optical signal gives flashing red alarm
// - own failure flashes red, status unreliable
// - quality at threshold raises manufacturer alarm
// - acknowledged optical alarms return while condition persists
// - status encoded normal..updating as zero..four
// - active flag reads one, writing zero acknowledges
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module iesm_monitor #(
    parameter int unsigned RES_W   = 16,                     // resolution bits
    parameter int unsigned WIN_CYC = iesm_pkg::RECUR_WIN_CYC // recur window
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // wishbone classic slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // scanner and cable readback pins, asynchronous
    input  wire logic                     phase_a_channel_i,
    input  wire logic                     phase_b_channel_i,
    input  wire logic                     index_i,
    input  wire logic                     out_a_fb_i,
    input  wire logic                     out_b_fb_i,
    input  wire logic                     out_idx_fb_i,
    input  wire logic                     led_open_i,
    input  wire logic                     signal_low_i,
    input  wire logic                     diag_fail_i,
    // adc values and update flag on clk_i
    input  wire logic [7:0]               photo_level_i,
    input  wire logic [7:0]               scan_quality_i,
    input  wire logic                     updating_i,
    // outputs
    output logic      [9:0]               led_current_o,
    output iesm_pkg::iesm_status_type     status_o,
    output logic                          irq_o
);
    import iesm_pkg::*;

    localparam int unsigned CNT_W = RES_W + 2;  // room for twice resolution

    typedef struct packed {
        logic [1:0]        prev_ab;   // last sampled phase state
        logic              idx_d;     // last sampled index
        logic              seen_idx;  // an index has passed since reset
        logic [CNT_W-1:0]  count;     // signed count since last index
        logic              dir_ok;    // direction already fixed
        logic              dir_up;    // direction of first step
        logic [PER_W-1:0]  per_cnt;   // cycles since last phase a rise
        logic [PER_W-1:0]  last_per;  // last full phase a period
        logic [7:0]        mm_ab;     // phase mismatch duration
        logic [7:0]        mm_idx;    // index mismatch duration
        logic [8:0]        tick;      // light loop divider
        logic [9:0]        led_cur;   // light source drive
        logic              ctrl_hc;   // high-current push-pull output fitted
        logic [RES_W-1:0]  res;       // counts per revolution
        logic [7:0]        qthr;      // quality threshold
        logic [7:0]        setp;      // light setpoint
        logic [NFAULT-1:0] fault;     // acknowledgeable fault flags
        logic [NFAULT-1:0] irq_st;    // sticky interrupt events
        logic [NFAULT-1:0] irq_mask;  // interrupt enables
        logic              ack;       // bus acknowledge
        logic [31:0]       rdat;      // bus read data
        logic [2:0]        status;    // encoded encoder status
    } iesm_mon_type;

    iesm_mon_type      s_r;
    iesm_mon_type      s_nxt;
    logic [8:0]        pins_s;    // synchronised pins
    logic [2:0]        ev;        // counting fault events for grading
    logic [1:0]        lvl [3];   // recurrence grades
    logic [CNT_W-1:0]  step_cnt;  // count after a step
    logic [CNT_W-1:0]  pos;       // count seen in the first direction
    logic [CNT_W-1:0]  cnt_abs;   // magnitude of count
    logic [NFAULT-1:0] fs;        // fault conditions this cycle
    logic [NFAULT-1:0] clr;       // acknowledge mask from software
    logic [31:0]       wmask;     // byte-lane write mask
    logic [31:0]       wval;      // merged write value
    logic [31:0]       old;       // present value of written register
    logic [1:0]        ab;        // phase state now
    logic [1:0]        chg;       // phase bits that changed
    logic              up;        // step direction
    logic              idx_rise;  // index leading edge
    logic              in_range;  // pulse rate within checkable range
    logic [PER_W-1:0]  per_lim;   // shortest checkable period
    logic              acc;       // bus cycle completing this edge
    logic [1:0]        lv;        // worst severity

    // pins enter through two flops before anything reads them
    iesm_sync #(
        .W (9)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({diag_fail_i, signal_low_i, led_open_i, out_idx_fb_i,
                 out_b_fb_i, out_a_fb_i, index_i, phase_b_channel_i,
                 phase_a_channel_i}),
        .q_o   (pins_s)
    );

    // one grader per counting fault
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_recur
            iesm_recur #(
                .WIN_CYC (WIN_CYC)
            ) u_recur (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .event_i (ev[g]),
                .level_o (lvl[g])
            );
        end
    endgenerate

    // whole monitor: counting, checks, light loop, registers, status
    always_comb begin
        s_nxt    = s_r;
        fs       = '0;
        clr      = '0;
        ev       = '0;
        ab       = {pins_s[0], pins_s[1]};
        chg      = ab ^ s_r.prev_ab;
        up       = s_r.prev_ab[1] ^ pins_s[1];
        idx_rise = pins_s[2] & ~s_r.idx_d;
        step_cnt = s_r.count;
        pos      = '0;
        cnt_abs  = s_r.count[CNT_W-1] ? CNT_W'(-s_r.count) : s_r.count;
        s_nxt.prev_ab = ab;
        s_nxt.idx_d   = pins_s[2];

        // both bits moving at once skips a state
        ev[0] = &chg;

        // index closes a revolution; its count is checked then cleared
        if (idx_rise) begin
            ev[1] = s_r.seen_idx && (cnt_abs != {2'b00, s_r.res})
                    && (s_r.count != '0);
            s_nxt.count    = '0;
            s_nxt.dir_ok   = 1'b0;
            s_nxt.seen_idx = 1'b1;
        end else if (^chg) begin
            // a legal step moves the count one place
            step_cnt = up ? CNT_W'(s_r.count + 1'b1)
                          : CNT_W'(s_r.count - 1'b1);
            s_nxt.count = step_cnt;
            if (!s_r.dir_ok) begin
                s_nxt.dir_ok = 1'b1;
                s_nxt.dir_up = up;
            end
            pos = (s_r.dir_ok ? s_r.dir_up : up) ? step_cnt
                                                 : CNT_W'(-step_cnt);
            if ($signed(pos) >= $signed({1'b0, s_r.res, 1'b0})) begin
                ev[2] = 1'b1;
            end else if (s_r.dir_ok && (up != s_r.dir_up)
                         && (pos == '0) && !pins_s[2]) begin
                ev[2] = 1'b1;
            end
            // restart the search so the alarm is not repeated each step
            if (ev[2]) begin
                s_nxt.count  = '0;
                s_nxt.dir_ok = 1'b0;
            end
        end
        fs[F_TRANS] = ev[0];
        fs[F_RES]   = ev[1];
        fs[F_MISS]  = ev[2];

        // pulse rate from the phase a period; standstill counts as in range
        if (pins_s[0] && !s_r.prev_ab[1]) begin
            s_nxt.last_per = s_r.per_cnt;
            s_nxt.per_cnt  = '0;
        end else if (s_r.per_cnt != '1) begin
            s_nxt.per_cnt = s_r.per_cnt + 1'b1;
        end
        if (s_r.per_cnt == '1) begin
            s_nxt.last_per = '1;
        end
        per_lim  = s_r.ctrl_hc ? PER_W'(PER_MIN_HC_CYC)
                               : PER_W'(PER_MIN_CYC);
        in_range = s_r.last_per >= per_lim;

        // a mismatch must outlast the driver delay before it counts
        if ((pins_s[0] != pins_s[3]) || (pins_s[1] != pins_s[4])) begin
            if (s_r.mm_ab != 8'hff) begin
                s_nxt.mm_ab = s_r.mm_ab + 8'h01;
            end
        end else begin
            s_nxt.mm_ab = 8'h00;
        end
        if (pins_s[2] != pins_s[5]) begin
            if (s_r.mm_idx != 8'hff) begin
                s_nxt.mm_idx = s_r.mm_idx + 8'h01;
            end
        end else begin
            s_nxt.mm_idx = 8'h00;
        end
        // output faults only flag; counting above never looks at them
        fs[F_OUTAB]  = in_range && (s_r.mm_ab >= 8'(SETTLE_CYC));
        fs[F_OUTIDX] = in_range && (s_r.mm_idx >= 8'(SETTLE_CYC));

        // slow light loop: one current step per tick towards the setpoint
        if (s_r.tick >= 9'(REG_TICK_CYC - 1)) begin
            s_nxt.tick = 9'h000;
            if ((photo_level_i < s_r.setp) && (s_r.led_cur != LED_MAX)) begin
                s_nxt.led_cur = s_r.led_cur + 10'h001;
            end else if ((photo_level_i > s_r.setp)
                         && (s_r.led_cur != 10'h000)) begin
                s_nxt.led_cur = s_r.led_cur - 10'h001;
            end
        end else begin
            s_nxt.tick = s_r.tick + 9'h001;
        end

        // level conditions re-set their flag every cycle they persist
        fs[F_RSRV]   = s_r.led_cur >= LED_RSRV;
        fs[F_LFAIL]  = pins_s[6] || ((s_r.led_cur == LED_MAX)
                       && (photo_level_i == 8'h00));
        fs[F_LOWSIG] = pins_s[7];
        fs[F_SYS]    = pins_s[8];
        fs[F_QUAL]   = scan_quality_i <= s_r.qthr;

        // bus: a cycle completes at the edge where ack is already high
        acc         = wb_cyc_i && wb_stb_i && s_r.ack;
        s_nxt.ack   = wb_cyc_i && wb_stb_i && !s_r.ack;
        wmask       = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        case (wb_adr_i)
            ADR_CTRL:   old = {31'h0, s_r.ctrl_hc};
            ADR_RES:    old = 32'(s_r.res);
            ADR_IRQMSK: old = 32'(s_r.irq_mask);
            ADR_QTHR:   old = {24'h0, s_r.qthr};
            ADR_SETP:   old = {24'h0, s_r.setp};
            default:    old = 32'h0;
        endcase
        wval = (old & ~wmask) | (wb_dat_i & wmask);
        if (acc && wb_we_i) begin
            case (wb_adr_i)
                ADR_CTRL:   s_nxt.ctrl_hc  = wval[0];
                ADR_RES:    s_nxt.res      = wval[RES_W-1:0];
                ADR_FAULT:  clr = wmask[NFAULT-1:0]
                                  & ~wb_dat_i[NFAULT-1:0];
                ADR_IRQMSK: s_nxt.irq_mask = wval[NFAULT-1:0];
                ADR_QTHR:   s_nxt.qthr     = wval[7:0];
                ADR_SETP:   s_nxt.setp     = wval[7:0];
                default:    ;
            endcase
        end

        // flags: a new condition wins over a clear in the same cycle
        s_nxt.fault = (s_r.fault & ~clr) | fs;
        s_nxt.irq_st = s_r.irq_st;
        if (acc && !wb_we_i && (wb_adr_i == ADR_IRQST)) begin
            s_nxt.irq_st = '0;
        end
        s_nxt.irq_st = s_nxt.irq_st | (fs & ~s_r.fault);

        // read data is latched with ack and held for the whole answer
        if (s_nxt.ack) begin
            case (wb_adr_i)
                ADR_CTRL:   s_nxt.rdat = {31'h0, s_r.ctrl_hc};
                ADR_RES:    s_nxt.rdat = 32'(s_r.res);
                ADR_FAULT:  s_nxt.rdat = 32'(s_r.fault);
                ADR_IRQST:  s_nxt.rdat = 32'(s_r.irq_st);
                ADR_IRQMSK: s_nxt.rdat = 32'(s_r.irq_mask);
                ADR_STATUS: s_nxt.rdat = {28'h0, s_r.fault[F_SYS],
                                          s_r.status};
                ADR_COUNT:  s_nxt.rdat = {{(32-CNT_W){s_r.count[CNT_W-1]}},
                                          s_r.count};
                ADR_QTHR:   s_nxt.rdat = {24'h0, s_r.qthr};
                ADR_SETP:   s_nxt.rdat = {24'h0, s_r.setp};
                ADR_LED:    s_nxt.rdat = {22'h0, s_r.led_cur};
                default:    s_nxt.rdat = 32'h0;
            endcase
        end

        // worst severity over all active flags
        lv = 2'h0;
        if (s_r.fault[F_TRANS] && (lvl[0] > lv)) begin
            lv = lvl[0];
        end
        if (s_r.fault[F_RES] && (lvl[1] > lv)) begin
            lv = lvl[1];
        end
        if (s_r.fault[F_MISS] && (lvl[2] > lv)) begin
            lv = lvl[2];
        end
        // a flag whose grader has decayed, or that has no grader, still warns
        if ((|s_r.fault[F_MISS:F_TRANS] || s_r.fault[F_OUTAB]
             || s_r.fault[F_OUTIDX] || s_r.fault[F_QUAL])
            && (lv < 2'h1)) begin
            lv = 2'h1;
        end
        if ((s_r.fault[F_RSRV] || s_r.fault[F_LOWSIG] || s_r.fault[F_SYS])
            && (lv < 2'h2)) begin
            lv = 2'h2;
        end
        if (s_r.fault[F_LFAIL]) begin
            lv = 2'h3;
        end
        s_nxt.status = updating_i ? ST_UPDATING : {1'b0, lv};
    end

    // state register; rest values make every output defined from reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r          <= '0;
            s_r.prev_ab  <= 2'h0;
            s_r.last_per <= '1;
            s_r.res      <= RES_W'(RES_RST);
            s_r.qthr     <= QTHR_RST;
            s_r.setp     <= SETP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o      = s_r.ack;
    assign wb_dat_o      = s_r.rdat;
    assign led_current_o = s_r.led_cur;
    assign status_o      = iesm_status_type'(s_r.status);
    assign irq_o         = |(s_r.irq_st & s_r.irq_mask);

endmodule : iesm_monitor

// ---- sim/iesm_monitor_props.sv ----
// port checker for the encoder monitor, bound to its top module
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module iesm_monitor_props
    import iesm_pkg::*;
(
    input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o, led_open_i, diag_fail_i, updating_i,
    input wire logic [9:0]  led_current_o,
    input iesm_status_type  status_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_unmapped_zero: assert property (
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h30
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // the light loop may only creep by one step
    chk_led_step: assert property (
        !$past(rst_i) |-> led_current_o - $past(led_current_o)
        inside {10'h0, 10'h1, 10'h3ff}) else $error("light step too big");
    chk_light_fail: assert property (
        led_open_i [*5] |-> status_o >= ST_CRITICAL) else $error("no red");
    chk_sys_fail: assert property (
        diag_fail_i [*5] |-> status_o >= ST_SERIOUS) else $error("no sys");
    chk_status_upd: assert property (
        updating_i [*3] |-> status_o == ST_UPDATING) else $error("no upd");
    chk_status_range: assert property (
        status_o <= ST_UPDATING) else $error("status code out of range");
endmodule : iesm_monitor_props
bind iesm_monitor iesm_monitor_props chk_inst (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .led_open_i,
    .diag_fail_i, .updating_i, .led_current_o, .status_o);

// ---- sim/iesm_scan_model.sv ----
// scanner and cable model driving the monitor's phase and readback pins
// assumes commands change just after clk_i edges
`timescale 1ns/1ps
module iesm_scan_model (
    input  wire logic       clk_i, step_i, dir_i, skip_i, idx_i,
    input  wire logic [2:0] brk_i,  // flip cable lanes {idx,b,a}
    output logic            a_o, b_o, i_o, fa_o, fb_o, fi_o
);
    logic [1:0] pos_r = 2'h0;  // position modulo four
    // a move changes one phase bit, a skip jumps two states (both bits)
    always @(posedge clk_i) begin
        if (skip_i || step_i) begin
            pos_r <= pos_r + (skip_i ? 2'h2 : dir_i ? 2'h1 : 2'h3);
        end
    end
    assign a_o = pos_r[1];
    assign b_o = pos_r[1] ^ pos_r[0];
    assign i_o = idx_i;
    // cable follows the internal levels unless a lane is broken
    assign {fi_o, fb_o, fa_o} = {i_o, b_o, a_o} ^ brk_i;
endmodule : iesm_scan_model

// ---- sim/iesm_monitor_bench.sv ----
// self-checking bench for the encoder monitor with a scanner model
// assumes 40 MHz clock, wishbone classic, short recurrence window
`timescale 1ns/1ps
module iesm_monitor_bench;
    import iesm_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h0, scan_quality_i = 8'h64;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic wb_ack_o, phase_a_channel_i, phase_b_channel_i, index_i, irq_o;
    logic out_a_fb_i, out_b_fb_i, out_idx_fb_i, led_open_i = 0;
    logic signal_low_i = 0, diag_fail_i = 0, updating_i = 0;
    logic stp = 0, dir = 1, skp = 0, idx = 0;  // scanner commands
    logic [2:0] brk = 3'h0;                    // broken cable lanes
    logic [7:0] photo = 8'h80;                 // photodiode light level
    logic [9:0] led_current_o;
    iesm_status_type status_o;
    int fail_count = 0, num_checks = 0;
    always #12.5 clk_i = ~clk_i;
    iesm_monitor #(.WIN_CYC(500)) iesm_monitor_inst (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .phase_a_channel_i,
        .phase_b_channel_i, .index_i, .out_a_fb_i, .out_b_fb_i,
        .out_idx_fb_i, .led_open_i, .signal_low_i, .diag_fail_i,
        .photo_level_i(photo), .scan_quality_i, .updating_i,
        .led_current_o, .status_o, .irq_o);
    iesm_scan_model iesm_scan_model_inst (.clk_i, .step_i(stp), .dir_i(dir),
        .skip_i(skp), .idx_i(idx), .brk_i(brk), .a_o(phase_a_channel_i),
        .b_o(phase_b_channel_i), .i_o(index_i), .fa_o(out_a_fb_i),
        .fb_o(out_b_fb_i), .fi_o(out_idx_fb_i));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle, held until ack, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        int n;
        n = 0;
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a;
        wb_dat_i <= d;
        do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 0; wb_stb_i <= 0;
        @(posedge clk_i);
        if (n >= 20) begin
            fail_count++; $display("BAD %0t no ack", $time); give_verdict();
        end
    endtask : bus
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 0);
        chk(rdat, e);
    endtask : rc
    task automatic wt(input int n); repeat (n) @(posedge clk_i); endtask : wt
    // n moves (or skips), each followed by quiet cycles for the syncs
    task automatic mv(input int n, input logic d, input logic s);
        repeat (n) begin
            stp <= !s; skp <= s; dir <= d; wt(1);
            stp <= 0; skp <= 0; wt(7);
        end
    endtask : mv
    task automatic ix(); idx <= 1; wt(6); idx <= 0; wt(6); endtask : ix
    task automatic t_trans();
        bus(1, ADR_IRQMSK, 1); mv(1, 1, 1);
        chk({31'h0, irq_o}, 32'h1);
        rc(ADR_FAULT, 32'h1); rc(ADR_STATUS, 32'h1);
        rc(ADR_IRQST, 32'h1); chk({31'h0, irq_o}, 32'h0);
        mv(1, 1, 1); rc(ADR_STATUS, 32'h2);
        bus(1, ADR_FAULT, 0); rc(ADR_FAULT, 32'h0);
        $display("done transition");
    endtask : t_trans
    task automatic t_count();
        bus(1, ADR_RES, 8); ix(); mv(5, 1, 0); rc(ADR_COUNT, 5);
        ix(); rc(ADR_FAULT, 32'h2); bus(1, ADR_FAULT, 0);
        mv(8, 1, 0); ix(); rc(ADR_FAULT, 32'h0);
        mv(16, 1, 0); rc(ADR_FAULT, 32'h4); bus(1, ADR_FAULT, 0);
        ix(); mv(2, 1, 0); mv(2, 0, 0); rc(ADR_FAULT, 32'h4);
        bus(1, ADR_FAULT, 0);
        $display("done counting");
    endtask : t_count
    task automatic t_out();
        brk <= 3'h1; wt(4200); rc(ADR_FAULT, 32'h8);
        rc(ADR_STATUS, 32'h1); brk <= 3'h4; wt(40);
        bus(1, ADR_FAULT, 0); rc(ADR_FAULT, 32'h10);
        brk <= 3'h0; wt(40); bus(1, ADR_FAULT, 0);
        $display("done output");
    endtask : t_out
    task automatic t_opt();
        logic [31:0] sx [3] = '{32'h2, 32'ha, 32'h1};
        photo <= 8'h7f; wt(400); photo <= 8'h80; rc(ADR_LED, 1);
        chk({22'h0, led_current_o}, 1);
        photo <= 8'h81; wt(400); photo <= 8'h80; rc(ADR_LED, 0);
        led_open_i <= 1; wt(10); rc(ADR_STATUS, 32'h3);
        bus(1, ADR_FAULT, 0); rc(ADR_FAULT, 32'h40);
        led_open_i <= 0; wt(10); bus(1, ADR_FAULT, 0);
        for (int k = 0; k < 3; k++) begin
            signal_low_i <= k == 0; diag_fail_i <= k == 1;
            scan_quality_i <= k == 2 ? 8'h0a : 8'h64; wt(10);
            rc(ADR_FAULT, 32'h80 << k); rc(ADR_STATUS, sx[k]);
            signal_low_i <= 0; diag_fail_i <= 0; scan_quality_i <= 8'h64;
            wt(10); bus(1, ADR_FAULT, 0); rc(ADR_FAULT, 0);
        end
        updating_i <= 1; wt(4); chk({29'h0, status_o}, 32'h4);
        updating_i <= 0; rc(8'h30, 0);
        $display("done optics");
    endtask : t_opt
    initial begin
        wt(6); rst_i <= 0; wt(3);
        t_trans(); t_count(); t_out(); t_opt();
        give_verdict();
    end
endmodule : iesm_monitor_bench
